// ===== core/ops_pkg.sv
// Package for the optical pickup servo front end: offsets, fields, reset values, timing
package ops_pkg;
  // APB register byte offsets
  localparam logic [7:0] OPS_CTRL_OFS = 8'h00;
  localparam logic [7:0] OPS_CMD_OFS = 8'h04;
  localparam logic [7:0] OPS_RAMP_OFS = 8'h08;
  localparam logic [7:0] OPS_LEVEL_OFS = 8'h0c;
  localparam logic [7:0] OPS_PID_OFS = 8'h10;
  localparam logic [7:0] OPS_GAIN_OFS = 8'h14;
  localparam logic [7:0] OPS_STATUS_OFS = 8'h18;
  localparam logic [7:0] OPS_RADIAL_OFS = 8'h1c;
  localparam logic [7:0] OPS_FE_OFS = 8'h20;
  // Control register fields
  localparam int OPS_CTRL_FOCUS_EN = 0;
  localparam int OPS_CTRL_SKE = 1;
  localparam int OPS_CTRL_RADIAL_EN = 2;
  localparam int OPS_CTRL_EXT_WIDE = 3;
  localparam int OPS_CTRL_AGC_EN = 4;
  localparam int OPS_CTRL_VREF_AUTO = 5;
  // Command register fields (write pulses)
  localparam int OPS_CMD_VREF_PRESET = 0;
  localparam int OPS_CMD_VREF_UP = 1;
  localparam int OPS_CMD_VREF_DOWN = 2;
  localparam int OPS_CMD_GAIN_DBL = 3;
  localparam int OPS_CMD_GAIN_HALF = 4;
  localparam int OPS_CMD_SLEDGE_FWD = 5;
  localparam int OPS_CMD_SLEDGE_REV = 6;
  localparam int OPS_CMD_RADIAL_INIT = 7;
  // Reference levels: 32 steps, preset step is the 2.5 V level
  localparam logic [4:0] OPS_VREF_PRESET = 5'h10;
  localparam logic [4:0] OPS_VREF_MAX = 5'h1f;
  // Reset values
  localparam logic [31:0] OPS_RAMP_RST = 32'h0010_4000;
  localparam logic [31:0] OPS_LEVEL_RST = 32'h0040_2080;
  localparam logic [31:0] OPS_PID_RST = 32'h0404_0404;
  localparam logic [7:0] OPS_GAIN_RST = 8'h10;
  // Timing
  localparam int OPS_CLK_HZ = 10000000;
  localparam int OPS_SAMPLE_HZ = 100000;
  localparam logic [7:0] OPS_SAMPLE_DIV = 8'(OPS_CLK_HZ / OPS_SAMPLE_HZ);
  localparam int OPS_LOSS_US = 3000;
  localparam logic [11:0] OPS_LOSS_SAMPLES = 12'(OPS_LOSS_US * (OPS_SAMPLE_HZ / 1000) / 1000);
  localparam int OPS_INIT_MS = 300;
  localparam logic [15:0] OPS_INIT_SAMPLES = 16'(OPS_INIT_MS * (OPS_SAMPLE_HZ / 1000));
  localparam logic [15:0] OPS_AGC_PERIOD = 16'h0020;
  localparam logic [7:0] OPS_TRACKS_NARROW = 8'h01;
  localparam logic [7:0] OPS_TRACKS_WIDE = 8'h03;

  typedef enum {OPS_IDLE, OPS_RAMP, OPS_ARMED, OPS_LOCK, OPS_DROP, OPS_RESTART} ops_fstate_type;

  // APB request and answer
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } ops_apb_req_type;
  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } ops_apb_rsp_type;
  // Six digitised diode currents
  typedef struct packed {
    logic [11:0] d1;
    logic [11:0] d2;
    logic [11:0] d3;
    logic [11:0] d4;
    logic [11:0] r1;
    logic [11:0] r2;
  } ops_diode_type;
  // Drive outputs
  typedef struct packed {
    logic [15:0] focus;
    logic [15:0] radial;
    logic [15:0] sledge;
    logic [4:0] vref;
    logic vref_auto;
    logic focus_ok;
    logic track_pos;
  } ops_drive_type;
endpackage

// ===== core/ops_servo.sv
// Optical pickup servo front end with APB registers
`timescale 1ns/1ps
`default_nettype none
module ops_servo (
  input wire logic sys_clk_in,
  input wire logic sys_rst_in,
  input wire logic clk_en_in,
  input wire ops_pkg::ops_apb_req_type apb_req_in,
  output ops_pkg::ops_apb_rsp_type apb_rsp_out,
  input wire ops_pkg::ops_diode_type diode_in,
  output ops_pkg::ops_drive_type drive_out,
  output logic focus_lost_out,
  output logic access_req_out
);
  import ops_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    ops_diode_type dsync1;
    ops_diode_type dsync2;
    ops_apb_rsp_type rsp;
    logic [5:0] ctrl;
    logic [31:0] ramp;
    logic [31:0] level;
    logic [31:0] pid;
    logic [7:0] gain;
    logic [4:0] vref;
    ops_fstate_type fstate;
    logic [7:0] div;
    logic [15:0] ramp_val;
    logic ramp_dn;
    logic [11:0] loss_cnt;
    logic focus_ok;
    logic focus_lost;
    logic [15:0] fe;
    logic [15:0] fe_prev;
    logic [19:0] integ;
    logic [15:0] lp;
    logic [15:0] focus_drv;
    logic [15:0] agc_cnt;
    logic [15:0] agc_acc;
    logic init_run;
    logic [15:0] init_cnt;
    logic [7:0] re_scale;
    logic [7:0] re_bias;
    logic [7:0] sum_weight;
    logic [15:0] tpos_hi;
    logic track_pos;
    logic [15:0] re;
    logic [15:0] rad_drv;
    logic [15:0] sledge_drv;
    logic [7:0] track_cnt;
    logic access;
  } ops_state_type;

  ops_state_type r;
  ops_state_type next_r;

  // Signed normalised difference (a-b)/(a+b), scaled to Q1.14
  function automatic logic signed [15:0] norm_diff(input logic [11:0] a, input logic [11:0] b);
    logic [12:0] s;
    logic signed [27:0] n;
    s = 13'(a) + 13'(b);
    n = 28'(signed'({1'b0, a}) - signed'({1'b0, b})) <<< 14;
    norm_diff = (s == 13'h0) ? 16'sh0 : 16'(n / signed'({15'h0, s}));
  endfunction

  // Truncating Q4 multiply helper for coefficient products, wraps on overflow
  function automatic logic [15:0] mul_q4(input logic [15:0] x, input logic [7:0] k);
    logic signed [23:0] p;
    p = signed'(x) * signed'({1'b0, k});
    mul_q4 = 16'(p >>> 4);
  endfunction

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic sample;
    logic wr;
    logic rd;
    logic [7:0] cmd;
    logic signed [15:0] fe_now;
    logic [12:0] ca;
    logic signed [15:0] sat;
    logic signed [17:0] tsum;
    logic signed [15:0] pid_out;
    logic zero_x;
    next_r = r;
    sample = 1'b0;
    cmd = 8'h0;
    // Pin synchroniser, two stages
    next_r.dsync1 = diode_in;
    next_r.dsync2 = r.dsync1;
    // APB slave: answers in the access cycle, zero wait
    wr = apb_req_in.psel && apb_req_in.penable && apb_req_in.pwrite;
    rd = apb_req_in.psel && !apb_req_in.penable && !apb_req_in.pwrite;
    next_r.rsp.pready = apb_req_in.psel && !apb_req_in.penable;
    next_r.rsp.pslverr = 1'b0;
    if (rd) begin
      next_r.rsp.prdata = 32'h0;
      unique case (apb_req_in.paddr)
        OPS_CTRL_OFS: next_r.rsp.prdata = {26'h0, r.ctrl};
        OPS_CMD_OFS: next_r.rsp.prdata = {27'h0, r.vref};
        OPS_RAMP_OFS: next_r.rsp.prdata = r.ramp;
        OPS_LEVEL_OFS: next_r.rsp.prdata = r.level;
        OPS_PID_OFS: next_r.rsp.prdata = r.pid;
        OPS_GAIN_OFS: next_r.rsp.prdata = {24'h0, r.gain};
        OPS_STATUS_OFS: next_r.rsp.prdata = {r.track_cnt, 16'h0, 1'b0, r.init_run,
            r.access, r.focus_lost, 3'(r.fstate), r.focus_ok};
        OPS_RADIAL_OFS: next_r.rsp.prdata = {8'h0, r.sum_weight, r.re_bias, r.re_scale};
        OPS_FE_OFS: next_r.rsp.prdata = {r.re, r.fe};
        default: next_r.rsp.pslverr = 1'b1;
      endcase
    end
    // Write refusal decided at setup so it stands with pready
    if (apb_req_in.psel && !apb_req_in.penable && apb_req_in.pwrite) begin
      unique case (apb_req_in.paddr)
        OPS_CTRL_OFS, OPS_CMD_OFS, OPS_RAMP_OFS, OPS_LEVEL_OFS, OPS_PID_OFS,
            OPS_GAIN_OFS: next_r.rsp.pslverr = 1'b0;
        default: next_r.rsp.pslverr = 1'b1;
      endcase
    end
    if (wr) begin
      unique case (apb_req_in.paddr)
        OPS_CTRL_OFS: next_r.ctrl = apb_req_in.pwdata[5:0];
        OPS_CMD_OFS: cmd = apb_req_in.pwdata[7:0];
        OPS_RAMP_OFS: next_r.ramp = apb_req_in.pwdata;
        OPS_LEVEL_OFS: next_r.level = apb_req_in.pwdata;
        OPS_PID_OFS: next_r.pid = apb_req_in.pwdata;
        OPS_GAIN_OFS: next_r.gain = apb_req_in.pwdata[7:0];
        default: ;
      endcase
    end
    // Reference preset and up/down steps, clamped to the 32 levels
    if (cmd[OPS_CMD_VREF_PRESET]) begin
      next_r.vref = OPS_VREF_PRESET;
    end else if (cmd[OPS_CMD_VREF_UP] && r.vref != OPS_VREF_MAX) begin
      next_r.vref = r.vref + 5'h1;
    end else if (cmd[OPS_CMD_VREF_DOWN] && r.vref != 5'h0) begin
      next_r.vref = r.vref - 5'h1;
    end
    // Gain switch rescales integrator, lead coefficient taken from bits 31:24
    if (cmd[OPS_CMD_GAIN_DBL] && r.gain[7] == 1'b0) begin
      next_r.gain = {r.gain[6:0], 1'b0};
      next_r.integ = 20'(signed'(r.integ) >>> 1);
      next_r.pid[7:0] = r.pid[31:24];
    end else if (cmd[OPS_CMD_GAIN_HALF] && r.gain > 8'h1) begin
      next_r.gain = {1'b0, r.gain[7:1]};
      next_r.integ = {r.integ[18:0], 1'b0};
      next_r.pid[7:0] = r.pid[31:24];
    end
    if (cmd[OPS_CMD_RADIAL_INIT]) begin
      next_r.init_run = 1'b1;
      next_r.init_cnt = 16'h0;
      next_r.tpos_hi = 16'h0;
    end
    // Sample period divider
    if (r.div == OPS_SAMPLE_DIV - 8'h1) begin
      next_r.div = 8'h0;
      sample = 1'b1;
    end else begin
      next_r.div = r.div + 8'h1;
    end
    // Signal conditioning on synchronised diodes
    ca = 13'(r.dsync2.d1) + 13'(r.dsync2.d2);
    if (r.ctrl[OPS_CTRL_SKE]) begin
      fe_now = 16'(norm_diff(r.dsync2.d1, r.dsync2.d2) <<< 1);
    end else begin
      fe_now = norm_diff(r.dsync2.d1, r.dsync2.d2) - norm_diff(r.dsync2.d3, r.dsync2.d4);
      ca = ca + 13'(r.dsync2.d3) + 13'(r.dsync2.d4);
    end
    sat = 16'(signed'({1'b0, r.dsync2.r1}) - signed'({1'b0, r.dsync2.r2}));
    tsum = 18'(ca) - 18'(mul_q4(16'(13'(r.dsync2.r1) + 13'(r.dsync2.r2)), r.sum_weight));
    zero_x = (signed'(r.fe) < 0) != (fe_now < 0);
    pid_out = 16'(signed'(mul_q4(r.fe, r.pid[15:8])) + signed'(r.integ[19:4])
        + signed'(mul_q4(16'(fe_now - signed'(r.fe)), r.pid[7:0])));
    if (sample && clk_en_in) begin
      next_r.fe = fe_now;
      next_r.fe_prev = r.fe;
      next_r.re = 16'(signed'(mul_q4(sat, r.re_scale)) + signed'(mul_q4(sat, r.re_bias)));
      next_r.track_pos = !tsum[17];
      // Focus ok against start and drop thresholds
      if (ca >= r.level[12:0]) begin
        next_r.focus_ok = 1'b1;
      end else if (ca < r.level[28:16]) begin
        next_r.focus_ok = 1'b0;
      end
      unique case (r.fstate)
        OPS_IDLE: begin
          next_r.focus_drv = 16'h0;
          if (r.ctrl[OPS_CTRL_FOCUS_EN]) next_r.fstate = OPS_RAMP;
        end
        OPS_RAMP, OPS_RESTART: begin
          // Triangle: offset bits 31:16, height bits 15:4, step bits 3:0
          if (r.ramp_dn) begin
            next_r.ramp_val = r.ramp_val - {12'h0, r.ramp[3:0]};
            if (signed'(r.ramp_val) <= -signed'({4'h0, r.ramp[15:4]})) next_r.ramp_dn = 1'b0;
          end else begin
            next_r.ramp_val = r.ramp_val + {12'h0, r.ramp[3:0]};
            if (signed'(r.ramp_val) >= signed'({4'h0, r.ramp[15:4]})) next_r.ramp_dn = 1'b1;
          end
          next_r.focus_drv = r.ramp_val + r.ramp[31:16];
          if (r.focus_ok && (fe_now >= signed'({4'h0, r.level[11:0]}))) begin
            next_r.fstate = OPS_ARMED;
          end
        end
        OPS_ARMED: if (zero_x) begin
          next_r.fstate = OPS_LOCK;
          next_r.integ = 20'h0;
          next_r.focus_lost = 1'b0;
        end
        OPS_LOCK, OPS_DROP: begin
          // PID with low-pass after it, integrator held in drop
          if (r.focus_ok) begin
            next_r.integ = 20'(signed'(r.integ) + signed'(mul_q4(r.fe, r.pid[31:24])));
            next_r.fstate = OPS_LOCK;
            next_r.loss_cnt = 12'h0;
          end else begin
            next_r.fstate = OPS_DROP;
            next_r.loss_cnt = r.loss_cnt + 12'h1;
            if (r.loss_cnt >= OPS_LOSS_SAMPLES) begin
              next_r.fstate = OPS_RESTART;
              next_r.focus_lost = 1'b1;
            end
          end
          next_r.lp = 16'(signed'(r.lp) + (signed'(pid_out - signed'(r.lp)) >>> r.pid[19:16]));
          // AGC: square test tone, response sign corrects gain
          next_r.agc_cnt = r.agc_cnt + 16'h1;
          if (r.ctrl[OPS_CTRL_AGC_EN]) begin
            next_r.agc_acc = r.agc_acc + (r.agc_cnt[4] ? r.fe : -r.fe);
            if (r.agc_cnt == OPS_AGC_PERIOD - 16'h1) begin
              next_r.agc_cnt = 16'h0;
              next_r.agc_acc = 16'h0;
              if (signed'(r.agc_acc) > 0 && r.gain != 8'hff) next_r.gain = r.gain + 8'h1;
              else if (signed'(r.agc_acc) < 0 && r.gain > 8'h1) next_r.gain = r.gain - 8'h1;
            end
          end
          next_r.focus_drv = 16'(mul_q4(r.lp, r.gain) + (r.ctrl[OPS_CTRL_AGC_EN]
              ? (r.agc_cnt[4] ? 16'h0040 : 16'hffc0) : 16'h0));
        end
      endcase
      if (!r.ctrl[OPS_CTRL_FOCUS_EN]) next_r.fstate = OPS_IDLE;
      // Radial level initialisation: open loop, adjusts scale, bias and weight
      if (r.init_run) begin
        next_r.init_cnt = r.init_cnt + 16'h1;
        next_r.tpos_hi = r.tpos_hi + {15'h0, r.track_pos};
        if (r.init_cnt[5:0] == 6'h3f) begin
          if (r.tpos_hi > {1'b0, r.init_cnt[15:1]}) next_r.sum_weight = r.sum_weight + 8'h1;
          else next_r.sum_weight = r.sum_weight - 8'h1;
          next_r.re_scale = (signed'(r.re) < 16'sh0400) ? r.re_scale + 8'h1 : r.re_scale;
          next_r.re_bias = (signed'(r.re) > 16'sh0400) ? r.re_bias - 8'h1 : r.re_bias;
        end
        if (r.init_cnt == OPS_INIT_SAMPLES - 16'h1) next_r.init_run = 1'b0;
        next_r.rad_drv = 16'h0;
      end else if (r.ctrl[OPS_CTRL_RADIAL_EN] && r.fstate == OPS_LOCK) begin
        // Track counting with return to the start track
        if (r.track_pos && !next_r.track_pos) begin
          next_r.track_cnt = (signed'(r.re) < 0) ? r.track_cnt - 8'h1 : r.track_cnt + 8'h1;
        end
        next_r.access = r.ctrl[OPS_CTRL_EXT_WIDE] && (r.track_cnt > OPS_TRACKS_WIDE)
            && (r.track_cnt < 8'h80);
        if (r.track_cnt == 8'h0 || r.access) begin
          next_r.rad_drv = 16'(mul_q4(r.re, r.pid[15:8]));
        end else begin
          next_r.rad_drv = r.track_cnt[7] ? 16'h1000 : 16'hf000;
        end
        if (!r.ctrl[OPS_CTRL_EXT_WIDE] && r.track_cnt != 8'h0 && r.track_cnt < OPS_TRACKS_NARROW)
          next_r.track_cnt = 8'h0;
      end else begin
        next_r.rad_drv = 16'h0;
        next_r.track_cnt = 8'h0;
        next_r.access = 1'b0;
      end
    end
    // Sledge steering
    if (cmd[OPS_CMD_SLEDGE_FWD]) next_r.sledge_drv = 16'h2000;
    else if (cmd[OPS_CMD_SLEDGE_REV]) next_r.sledge_drv = 16'he000;
    else if (cmd != 8'h0) next_r.sledge_drv = 16'h0;
    if (!clk_en_in) begin
      next_r = r;
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      r <= '0;
      r.fstate <= OPS_IDLE;
      r.ramp <= OPS_RAMP_RST;
      r.level <= OPS_LEVEL_RST;
      r.pid <= OPS_PID_RST;
      r.gain <= OPS_GAIN_RST;
      r.vref <= OPS_VREF_PRESET;
      r.re_scale <= 8'h10;
      r.sum_weight <= 8'h10;
    end else begin
      r <= next_r;
    end
  end

  // Outputs straight from state
  assign apb_rsp_out = r.rsp;
  assign drive_out = {r.focus_drv, r.rad_drv, r.sledge_drv, r.vref,
      r.ctrl[OPS_CTRL_VREF_AUTO], r.focus_ok, r.track_pos};
  assign focus_lost_out = r.focus_lost;
  assign access_req_out = r.access;
endmodule // ops_servo
`default_nettype wire

// ===== sim/ops_servo_props.sv
// Port-level assertions for the servo front end
`timescale 1ns/1ps
`default_nettype none
module ops_servo_props
  import ops_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic sys_rst_in,
  input wire logic clk_en_in,
  input wire ops_pkg::ops_apb_req_type apb_req_in,
  input wire ops_pkg::ops_apb_rsp_type apb_rsp_out,
  input wire ops_pkg::ops_diode_type diode_in,
  input wire ops_pkg::ops_drive_type drive_out,
  input wire logic focus_lost_out,
  input wire logic access_req_out
);
  logic [13:0] ap_sum;
  logic acc_wr;
  logic cmd_wr;
  int low_cnt;
  int hi_cnt;
  // ---------------------------------------------
  // Helper logic
  // ---------------------------------------------
  // Aperture sum and completed write strobes
  assign ap_sum = 14'(diode_in.d1) + 14'(diode_in.d2) + 14'(diode_in.d3) + 14'(diode_in.d4);
  assign acc_wr = apb_req_in.psel && apb_req_in.penable && apb_req_in.pwrite && apb_rsp_out.pready;
  assign cmd_wr = acc_wr && (apb_req_in.paddr == OPS_CMD_OFS);
  // Run lengths of dark aperture and of clean on-track light
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      low_cnt <= 0;
      hi_cnt <= 0;
    end else begin
      low_cnt <= (ap_sum < 14'h0040) ? low_cnt + 1 : 0;
      hi_cnt <= (ap_sum > 14'h0100 && diode_in.r1 == 12'h000 && diode_in.r2 == 12'h000) ?
        hi_cnt + 1 : 0;
    end
  end
  // ---------------------------------------------
  // Assertions
  // ---------------------------------------------
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (sys_rst_in);
  a_ready_after_setup: assert property (apb_req_in.psel && !apb_req_in.penable |=>
    apb_rsp_out.pready) else $error("no ready after setup");
  a_ready_single: assert property (apb_rsp_out.pready |=> !apb_rsp_out.pready)
    else $error("ready held too long");
  a_readonly_refused: assert property (apb_req_in.psel && !apb_req_in.penable &&
    apb_req_in.pwrite && apb_req_in.paddr == OPS_STATUS_OFS |=> apb_rsp_out.pslverr)
    else $error("read-only write accepted");
  a_unmapped_refused: assert property (apb_req_in.psel && !apb_req_in.penable &&
    apb_req_in.paddr > OPS_FE_OFS |=> apb_rsp_out.pslverr) else $error("unmapped accepted");
  a_reset_idle: assert property (disable iff (1'b0) $fell(sys_rst_in) |->
    drive_out.focus == 16'h0000 && drive_out.sledge == 16'h0000 && drive_out.radial == 16'h0000
    && drive_out.vref == OPS_VREF_PRESET && !drive_out.focus_ok) else $error("not idle");
  a_vref_by_cmd: assert property ($changed(drive_out.vref) |->
    $past(cmd_wr) || $past(cmd_wr, 2)) else $error("reference moved without command");
  a_auto_by_ctrl: assert property ($changed(drive_out.vref_auto) |->
    $past(acc_wr && apb_req_in.paddr == OPS_CTRL_OFS)) else $error("auto mode moved alone");
  a_sledge_fwd: assert property (cmd_wr && apb_req_in.pwdata == 32'h0000_0020 |->
    ##[1:400] $signed(drive_out.sledge) > 0) else $error("sledge not forward");
  a_sledge_rev: assert property (cmd_wr && apb_req_in.pwdata == 32'h0000_0040 |->
    ##[1:400] $signed(drive_out.sledge) < 0) else $error("sledge not reverse");
  a_drop_clears: assert property (low_cnt > 400 |-> !drive_out.focus_ok)
    else $error("focus ok kept in drop");
  a_track_flag: assert property (hi_cnt > 400 |-> drive_out.track_pos)
    else $error("track flag low");
  // Main scenarios reached
  c_refused: cover property (apb_rsp_out.pready && apb_rsp_out.pslverr);
  c_focus_ok: cover property ($rose(drive_out.focus_ok));
  c_sledge: cover property (cmd_wr && apb_req_in.pwdata == 32'h0000_0040);
endmodule // ops_servo_props
bind ops_servo ops_servo_props i_props (.sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in),
  .clk_en_in(clk_en_in), .apb_req_in(apb_req_in), .apb_rsp_out(apb_rsp_out),
  .diode_in(diode_in), .drive_out(drive_out), .focus_lost_out(focus_lost_out),
  .access_req_out(access_req_out));
`default_nettype wire

// ===== sim/ops_diode_model.sv
// Photodiode converter model with one-code dither on every cycle
`timescale 1ns/1ps
`default_nettype none
module ops_diode_model
  import ops_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic [11:0] ap_level_in,
  input wire logic [11:0] sat_level_in,
  output ops_pkg::ops_diode_type diode_out
);
  logic tog = 1'b0;
  // Converter noise toggles d1, d4 and a nonzero r1 by one code; d2, d3 and r2 sit still
  always_ff @(posedge sys_clk_in) begin
    tog <= !tog;
    diode_out.d1 <= ap_level_in + 12'(tog);
    diode_out.d2 <= ap_level_in;
    diode_out.d3 <= ap_level_in;
    diode_out.d4 <= ap_level_in + 12'(!tog);
    diode_out.r1 <= (sat_level_in == 12'h000) ? 12'h000 : sat_level_in + 12'(tog);
    diode_out.r2 <= sat_level_in;
  end
endmodule // ops_diode_model
`default_nettype wire

// ===== sim/ops_servo_bench.sv
// Self-checking bench for the servo front end register and drive behaviour
`timescale 1ns/1ps
`default_nettype none
module ops_servo_bench;
  import ops_pkg::*;
  logic sys_clk_in;
  logic sys_rst_in;
  logic clk_en_in;
  ops_apb_req_type apb_req;
  ops_apb_rsp_type apb_rsp;
  ops_diode_type diode;
  ops_drive_type drive;
  logic [11:0] ap_level;
  logic [11:0] sat_level;
  logic [31:0] rdat;
  logic rerr;
  int bad_count;
  int total_checks;
  int i;
  // ---------------------------------------------
  // Clock, partner and design
  // ---------------------------------------------
  initial begin
    sys_clk_in = 1'b0;
    forever #50 sys_clk_in = !sys_clk_in;
  end
  ops_diode_model i_model (.sys_clk_in(sys_clk_in), .ap_level_in(ap_level),
    .sat_level_in(sat_level), .diode_out(diode));
  ops_servo i_dut (.sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in), .clk_en_in(clk_en_in),
    .apb_req_in(apb_req), .apb_rsp_out(apb_rsp), .diode_in(diode), .drive_out(drive),
    .focus_lost_out(), .access_req_out());
  // ---------------------------------------------
  // Tasks
  // ---------------------------------------------
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask
  // One APB transfer; held until ready is seen at a rising edge
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge sys_clk_in) apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge sys_clk_in) apb_req.penable <= 1'b1;
    // Ready, data and error are taken at the rising edge that ends the access
    do begin
      @(posedge sys_clk_in);
      n++;
    end while (apb_rsp.pready !== 1'b1 && n < 40);
    if (n >= 40) bad_count++;
    rdat = apb_rsp.prdata;
    rerr = apb_rsp.pslverr;
    apb_req <= '0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic e);
    xfer(1'b1, a, d);
    chk("write error", 32'(e), 32'(rerr));
  endtask
  task automatic rd(input string name, input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    chk("read error", 32'h0, 32'(rerr));
    chk(name, exp, rdat);
  endtask
  task automatic tally_and_finish();
    if (bad_count == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // Watchdog well beyond the expected run
  initial begin
    #2000000;
    bad_count++;
    tally_and_finish();
  end
  // ---------------------------------------------
  // Main sequence
  // ---------------------------------------------
  initial begin
    apb_req = '0;
    sys_rst_in = 1'b1;
    clk_en_in = 1'b1;
    ap_level = 12'h000;
    sat_level = 12'h000;
    bad_count = 0;
    total_checks = 0;
    repeat (5) @(posedge sys_clk_in);
    sys_rst_in <= 1'b0;
    rd("ramp", OPS_RAMP_OFS, OPS_RAMP_RST);
    rd("level", OPS_LEVEL_OFS, OPS_LEVEL_RST);
    rd("pid", OPS_PID_OFS, OPS_PID_RST);
    rd("gain", OPS_GAIN_OFS, {24'h0, OPS_GAIN_RST});
    rd("vref reset", OPS_CMD_OFS, 32'h10);
    // Step up past the top level, then down and preset
    for (i = 0; i < 17; i++) wr(OPS_CMD_OFS, 32'h2, 1'b0);
    rd("vref top", OPS_CMD_OFS, 32'h1f);
    wr(OPS_CMD_OFS, 32'h4, 1'b0);
    rd("vref down", OPS_CMD_OFS, 32'h1e);
    wr(OPS_CMD_OFS, 32'h1, 1'b0);
    rd("vref preset", OPS_CMD_OFS, 32'h10);
    chk("vref pin", 32'h10, 32'(drive.vref));
    // Automatic reference mode
    wr(OPS_CTRL_OFS, 32'h20, 1'b0);
    rd("ctrl", OPS_CTRL_OFS, 32'h20);
    chk("vref auto", 32'h1, 32'(drive.vref_auto));
    // Refused writes leave state alone
    wr(OPS_STATUS_OFS, 32'hffff_ffff, 1'b1);
    wr(8'h40, 32'h1, 1'b1);
    rd("ctrl kept", OPS_CTRL_OFS, 32'h20);
    // Gain switching with differential reload
    wr(OPS_PID_OFS, 32'h0a04_0403, 1'b0);
    wr(OPS_CMD_OFS, 32'h8, 1'b0);
    rd("gain x2", OPS_GAIN_OFS, 32'h20);
    rd("pid reload", OPS_PID_OFS, 32'h0a04_040a);
    wr(OPS_CMD_OFS, 32'h10, 1'b0);
    wr(OPS_CMD_OFS, 32'h10, 1'b0);
    rd("gain half", OPS_GAIN_OFS, 32'h08);
    // Sledge both ways, then stopped by another command
    wr(OPS_CMD_OFS, 32'h20, 1'b0);
    repeat (400) @(posedge sys_clk_in);
    chk("sledge fwd", 32'h1, 32'($signed(drive.sledge) > 0));
    wr(OPS_CMD_OFS, 32'h40, 1'b0);
    repeat (400) @(posedge sys_clk_in);
    chk("sledge rev", 32'h1, 32'($signed(drive.sledge) < 0));
    wr(OPS_CMD_OFS, 32'h1, 1'b0);
    repeat (400) @(posedge sys_clk_in);
    chk("sledge stop", 32'h0, 32'(drive.sledge));
    // Bright aperture with dark satellites, then drop-out
    wr(OPS_CTRL_OFS, 32'h21, 1'b0);
    ap_level <= 12'h100;
    repeat (600) @(posedge sys_clk_in);
    chk("focus ok", 32'h1, 32'(drive.focus_ok));
    chk("track flag", 32'h1, 32'(drive.track_pos));
    ap_level <= 12'h004;
    repeat (600) @(posedge sys_clk_in);
    chk("focus drop", 32'h0, 32'(drive.focus_ok));
    tally_and_finish();
  end
endmodule // ops_servo_bench
`default_nettype wire
